// ==== include/smbus_cfg_pkg.sv ====
package smbus_cfg_pkg;
  localparam int NUM_BYTES = 4;
  localparam logic [2:0] NUM_IDX = 3'h4;
  localparam logic [7:0] NUM_CNT = 8'h04;
  // address byte is d4 for writes and d5 for reads
  localparam logic [6:0] SLAVE_ADDR = 7'h6a;
  localparam int CMD_TYPE_BIT = 7;
  localparam logic [7:0] CMD_BLOCK = 8'h00;
  localparam logic [5:0] CMD_BYTE_PREFIX = 6'h20;
  localparam int SEL_BIT = 3;
  localparam int SWCTL_BIT = 0;
  localparam logic [7:0] REG0_DEFAULT = 8'h02;
  localparam logic [7:0] REG1_DEFAULT = 8'h00;
  localparam logic [7:0] REG2_DEFAULT = 8'h00;
  localparam logic [7:0] REG3_DEFAULT = 8'h00;
  localparam logic [NUM_BYTES-1:0][7:0] REGS_DEFAULT = {REG3_DEFAULT, REG2_DEFAULT, REG1_DEFAULT, REG0_DEFAULT};
  localparam logic [7:0] BAD_IDX_DATA = 8'hff;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam int CLK_PERIOD_NS = 5;
  // faster than standard smbus so a full sequence stays short; a quarter must stay well above the 3-cycle sync lag
  localparam int SCL_PERIOD_NS = 2000;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [9:0] QTR_LAST = 10'(QTR_CYC - 1);
  typedef enum logic [1:0] {OP_BYTE_WR, OP_BYTE_RD, OP_BLK_WR, OP_BLK_RD} op_e;
endpackage

// ==== include/smbus_if.sv ====
`timescale 1ns/1ps
interface smbus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // open-drain wired and with pull-ups
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
                input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

// ==== src/smbus_config_slave.sv ====
`timescale 1ns/1ps
module smbus_config_slave
  import smbus_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  smbus_if.dev bus,
  input wire logic power_down_in,
  input wire logic ref_out_freq_strap,
  input wire logic reference_clock_in,
  output logic ref_out_o,
  output logic ref_out_oe,
  output logic freq_100_sel,
  output logic powered_down,
  output logic [NUM_BYTES-1:0][7:0] cfg_bytes
);
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_SKIP} dev_st_e;
  typedef enum logic [1:0] {K_ADDR, K_CMD, K_CNT, K_DATA} byte_k_e;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [1:0] strap_sy;
    logic [1:0] pd_sy;
    logic [1:0] ref_sy;
    logic scl_d;
    logic sda_d;
    dev_st_e st;
    byte_k_e kind;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] txsh;
    logic rnw;
    logic blk;
    logic txcnt;
    logic [2:0] idx;
    logic [7:0] wleft;
    logic sda_low;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic strap_val;
    logic freq;
    logic ref_o;
    logic pd;
    logic [NUM_BYTES-1:0][7:0] regs;
  } dev_s;

  dev_s s_r;
  dev_s s_nxt;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_now;

  // indices past the last byte read back as all ones
  function automatic logic [7:0] rd_byte(input logic [NUM_BYTES-1:0][7:0] r, input logic [2:0] i);
    rd_byte = (i < NUM_IDX) ? r[i[1:0]] : BAD_IDX_DATA;
  endfunction

  // edges are taken on the second sync stage and its delayed copy only
  assign sda_now = s_r.sda_sy[1];
  assign scl_rise = s_r.scl_sy[1] && !s_r.scl_d;
  assign scl_fall = !s_r.scl_sy[1] && s_r.scl_d;
  assign start_seen = s_r.scl_sy[1] && s_r.scl_d && s_r.sda_d && !sda_now;
  assign stop_seen = s_r.scl_sy[1] && s_r.scl_d && !s_r.sda_d && sda_now;

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_sy = {s_r.scl_sy[0], bus.scl};
    s_nxt.sda_sy = {s_r.sda_sy[0], bus.sda};
    s_nxt.strap_sy = {s_r.strap_sy[0], ref_out_freq_strap};
    s_nxt.pd_sy = {s_r.pd_sy[0], power_down_in};
    s_nxt.ref_sy = {s_r.ref_sy[0], reference_clock_in};
    s_nxt.scl_d = s_r.scl_sy[1];
    s_nxt.sda_d = sda_now;
    s_nxt.ref_o = s_r.ref_sy[1];
    s_nxt.pd = s_r.pd_sy[1];
    // the strap is read only after the sync chain has filled with real pin values
    if (!s_r.strap_done) begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      if (s_r.strap_cnt == STRAP_WAIT) begin
        s_nxt.strap_done = 1'b1;
        s_nxt.strap_val = s_r.strap_sy[1];
        s_nxt.regs[0][SEL_BIT] = s_r.strap_sy[1];
      end
    end
    s_nxt.freq = s_r.regs[0][SWCTL_BIT] ? s_r.regs[0][SEL_BIT] : s_r.strap_val;

    if (start_seen) begin
      // repeated start keeps block flag and index from the command phase
      s_nxt.st = ST_RX;
      s_nxt.kind = K_ADDR;
      s_nxt.bitn = 4'h0;
      s_nxt.rnw = 1'b0;
      s_nxt.sda_low = 1'b0;
    end else if (stop_seen) begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_low = 1'b0;
    end else begin
      unique case (s_r.st)
        ST_IDLE, ST_SKIP: begin
          s_nxt.sda_low = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda_now};
            s_nxt.bitn = s_r.bitn + 4'h1;
          end else if (scl_fall && s_r.bitn == 4'h8) begin
            s_nxt.bitn = 4'h0;
            s_nxt.st = ST_RX_ACK;
            s_nxt.sda_low = 1'b1;
            unique case (s_r.kind)
              K_ADDR: begin
                if (s_r.sh[7:1] != SLAVE_ADDR) begin
                  s_nxt.st = ST_SKIP;
                  s_nxt.sda_low = 1'b0;
                end else begin
                  s_nxt.rnw = s_r.sh[0];
                  s_nxt.kind = K_CMD;
                  s_nxt.txcnt = s_r.blk;
                  s_nxt.txsh = s_r.blk ? NUM_CNT : rd_byte(s_r.regs, s_r.idx);
                end
              end
              K_CMD: begin
                // low bits of a block command are not checked, offset is forced to zero
                s_nxt.blk = !s_r.sh[CMD_TYPE_BIT];
                s_nxt.idx = s_r.sh[CMD_TYPE_BIT] ? {1'b0, s_r.sh[1:0]} : 3'h0;
                s_nxt.wleft = s_r.sh[CMD_TYPE_BIT] ? 8'h01 : 8'h00;
                s_nxt.kind = s_r.sh[CMD_TYPE_BIT] ? K_DATA : K_CNT;
              end
              K_CNT: begin
                s_nxt.wleft = s_r.sh;
                s_nxt.kind = K_DATA;
              end
              K_DATA: begin
                // bytes beyond the count or the last index are acked but dropped
                if (s_r.wleft != 8'h00 && s_r.idx < NUM_IDX) begin
                  s_nxt.regs[s_r.idx[1:0]] = s_r.sh;
                  s_nxt.idx = s_r.idx + 3'h1;
                  s_nxt.wleft = s_r.wleft - 8'h01;
                end
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            if (s_r.rnw) begin
              s_nxt.st = ST_TX;
              s_nxt.sda_low = !s_r.txsh[7];
            end else begin
              s_nxt.st = ST_RX;
              s_nxt.sda_low = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (s_r.bitn == 4'h7) begin
              s_nxt.st = ST_TX_ACK;
              s_nxt.sda_low = 1'b0;
              s_nxt.bitn = 4'h0;
            end else begin
              s_nxt.txsh = {s_r.txsh[6:0], 1'b0};
              s_nxt.sda_low = !s_r.txsh[6];
              s_nxt.bitn = s_r.bitn + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            if (!sda_now) begin
              if (!s_r.txcnt && s_r.idx != 3'h7) begin
                s_nxt.idx = s_r.idx + 3'h1;
              end
              // index saturates at 7 so a long read keeps returning the fill value instead of wrapping
              s_nxt.txsh = rd_byte(s_r.regs, (s_r.txcnt || s_r.idx == 3'h7) ? s_r.idx : s_r.idx + 3'h1);
              s_nxt.txcnt = 1'b0;
              s_nxt.bitn = 4'h1;
            end else begin
              s_nxt.st = ST_SKIP;
            end
          end else if (scl_fall && s_r.bitn == 4'h1) begin
            s_nxt.st = ST_TX;
            s_nxt.bitn = 4'h0;
            s_nxt.sda_low = !s_r.txsh[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.regs <= REGS_DEFAULT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = s_r.sda_low;
  assign ref_out_o = s_r.ref_o;
  // pin turns into the reference output once the strap is taken
  assign ref_out_oe = s_r.strap_done;
  assign freq_100_sel = s_r.freq;
  assign powered_down = s_r.pd;
  assign cfg_bytes = s_r.regs;
endmodule

// ==== src/smbus_config_host.sv ====
`timescale 1ns/1ps
module smbus_config_host
  import smbus_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  smbus_if.host bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire op_e req_op,
  input wire logic [1:0] req_offset,
  input wire logic [7:0] req_count,
  input wire logic [NUM_BYTES-1:0][7:0] req_wdata,
  output logic done,
  output logic nack_err,
  output logic [7:0] rd_count,
  output logic [NUM_BYTES-1:0][7:0] rd_data
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_ACK_RX, H_RX, H_ACK_TX, H_STOP} host_st_e;
  typedef enum logic [2:0] {P_ADDR, P_CMD, P_CNT, P_DATA, P_RADDR, P_RCNT, P_RDATA} phase_e;

  typedef struct packed {
    logic [1:0] sda_sy;
    host_st_e st;
    phase_e ph;
    logic [1:0] q;
    logic [9:0] tick;
    logic [3:0] bitn;
    logic [7:0] sh;
    op_e op;
    logic [1:0] off;
    logic [7:0] cnt;
    logic [2:0] idx;
    logic last;
    logic nack;
    logic scl_hi;
    logic sda_hi;
    logic done;
    logic [7:0] rcount;
    logic [NUM_BYTES-1:0][7:0] wdata;
    logic [NUM_BYTES-1:0][7:0] rdata;
  } host_s;

  host_s s_r;
  host_s s_nxt;
  logic qend;
  logic is_blk;
  logic sda_line;

  assign qend = s_r.tick == QTR_LAST;
  assign is_blk = s_r.op == OP_BLK_WR || s_r.op == OP_BLK_RD;

  always_comb begin
    s_nxt = s_r;
    sda_line = 1'b1;
    s_nxt.sda_sy = {s_r.sda_sy[0], bus.sda};
    s_nxt.done = 1'b0;
    s_nxt.scl_hi = s_r.q[1];
    if (s_r.st != H_IDLE) begin
      s_nxt.tick = qend ? 10'h000 : s_r.tick + 10'h001;
      if (qend) begin
        s_nxt.q = s_r.q + 2'h1;
      end
    end
    unique case (s_r.st)
      H_IDLE: begin
        s_nxt.scl_hi = 1'b1;
        if (req_valid) begin
          s_nxt.st = H_START;
          s_nxt.ph = P_ADDR;
          s_nxt.op = req_op;
          s_nxt.off = req_offset;
          s_nxt.cnt = (req_count > NUM_CNT) ? NUM_CNT : req_count;
          s_nxt.wdata = req_wdata;
          s_nxt.nack = 1'b0;
          s_nxt.rcount = 8'h00;
          s_nxt.tick = 10'h000;
          s_nxt.q = 2'h0;
        end
      end
      H_START: begin
        s_nxt.scl_hi = s_r.q == 2'h1 || s_r.q == 2'h2;
        sda_line = !s_r.q[1];
        if (qend && s_r.q == 2'h3) begin
          s_nxt.st = H_TX;
          s_nxt.bitn = 4'h0;
          s_nxt.sh = {SLAVE_ADDR, s_r.ph == P_RADDR};
        end
      end
      H_TX: begin
        sda_line = s_r.sh[7];
        if (qend && s_r.q == 2'h3) begin
          s_nxt.sh = {s_r.sh[6:0], 1'b0};
          s_nxt.bitn = s_r.bitn + 4'h1;
          if (s_r.bitn == 4'h7) begin
            s_nxt.st = H_ACK_RX;
          end
        end
      end
      H_ACK_RX: begin
        if (qend && s_r.q == 2'h2) begin
          s_nxt.nack = s_r.sda_sy[1];
        end
        if (qend && s_r.q == 2'h3) begin
          s_nxt.bitn = 4'h0;
          s_nxt.st = H_TX;
          if (s_r.nack) begin
            s_nxt.st = H_STOP;
          end else begin
            unique case (s_r.ph)
              P_ADDR: begin
                s_nxt.ph = P_CMD;
                s_nxt.sh = is_blk ? CMD_BLOCK : {CMD_BYTE_PREFIX, s_r.off};
              end
              P_CMD: begin
                s_nxt.idx = 3'h0;
                if (s_r.op == OP_BYTE_RD || s_r.op == OP_BLK_RD) begin
                  s_nxt.st = H_START;
                  s_nxt.ph = P_RADDR;
                end else if (s_r.op == OP_BLK_WR) begin
                  s_nxt.ph = P_CNT;
                  s_nxt.sh = s_r.cnt;
                end else begin
                  s_nxt.ph = P_DATA;
                  s_nxt.cnt = 8'h01;
                  s_nxt.sh = s_r.wdata[0];
                end
              end
              P_CNT: begin
                s_nxt.ph = P_DATA;
                s_nxt.sh = s_r.wdata[0];
                if (s_r.cnt == 8'h00) begin
                  s_nxt.st = H_STOP;
                end
              end
              P_DATA: begin
                s_nxt.idx = s_r.idx + 3'h1;
                s_nxt.sh = s_r.wdata[s_nxt.idx[1:0]];
                if ({5'h00, s_r.idx + 3'h1} >= s_r.cnt) begin
                  s_nxt.st = H_STOP;
                end
              end
              P_RADDR: begin
                s_nxt.st = H_RX;
                s_nxt.ph = is_blk ? P_RCNT : P_RDATA;
                s_nxt.cnt = 8'h01;
                s_nxt.rcount = 8'h01;
              end
              default: begin
                s_nxt.st = H_STOP;
              end
            endcase
          end
        end
      end
      H_RX: begin
        if (qend && s_r.q == 2'h2) begin
          s_nxt.sh = {s_r.sh[6:0], s_r.sda_sy[1]};
        end
        if (qend && s_r.q == 2'h3) begin
          s_nxt.bitn = s_r.bitn + 4'h1;
          if (s_r.bitn == 4'h7) begin
            s_nxt.st = H_ACK_TX;
            if (s_r.ph == P_RCNT) begin
              s_nxt.rcount = s_r.sh;
              s_nxt.cnt = (s_r.sh > NUM_CNT) ? NUM_CNT : s_r.sh;
              s_nxt.last = s_r.sh == 8'h00;
            end else begin
              s_nxt.rdata[s_r.idx[1:0]] = s_r.sh;
              s_nxt.idx = s_r.idx + 3'h1;
              s_nxt.cnt = s_r.cnt - 8'h01;
              s_nxt.last = s_r.cnt == 8'h01;
            end
          end
        end
      end
      H_ACK_TX: begin
        sda_line = s_r.last;
        if (qend && s_r.q == 2'h3) begin
          s_nxt.bitn = 4'h0;
          s_nxt.ph = P_RDATA;
          s_nxt.st = s_r.last ? H_STOP : H_RX;
        end
      end
      H_STOP: begin
        s_nxt.scl_hi = s_r.q != 2'h0;
        sda_line = s_r.q[1];
        if (qend && s_r.q == 2'h3) begin
          s_nxt.st = H_IDLE;
          s_nxt.done = 1'b1;
        end
      end
    endcase
    // hold data one cycle past the scl fall so it never moves while scl is high
    s_nxt.sda_hi = (s_r.q == 2'h0 && s_r.tick == 10'h000) ? s_r.sda_hi : sda_line;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.scl_hi <= 1'b1;
      s_r.sda_hi <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = !s_r.scl_hi;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = !s_r.sda_hi;
  assign req_ready = s_r.st == H_IDLE;
  assign done = s_r.done;
  assign nack_err = s_r.nack;
  assign rd_count = s_r.rcount;
  assign rd_data = s_r.rdata;
endmodule

// ==== verif/smbus_cfg_checker.sv ====
`timescale 1ns/1ps
module smbus_cfg_checker
  import smbus_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // low phase lasts one quarter (start, stop), two (plain bit) or three (first bit after a start)
  localparam logic [11:0] LO_MIN = 12'(QTR_CYC - 4);
  localparam logic [11:0] LO_MAX = 12'(QTR_CYC + 4);
  localparam logic [11:0] LO2_MIN = 12'(2 * QTR_CYC - 4);
  localparam logic [11:0] LO2_MAX = 12'(2 * QTR_CYC + 4);
  localparam logic [11:0] LO3_MIN = 12'(3 * QTR_CYC - 4);
  localparam logic [11:0] LO3_MAX = 12'(3 * QTR_CYC + 4);
  localparam logic [11:0] HI_MIN = 12'(2 * QTR_CYC - 4);
  logic [11:0] lo_r;
  logic [11:0] hi_r;

  // hi_r starts saturated so the first start after reset counts as a long idle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lo_r <= '0;
      hi_r <= '1;
    end else begin
      lo_r <= scl ? '0 : ((lo_r == '1) ? lo_r : lo_r + 12'h001);
      hi_r <= !scl ? '0 : ((hi_r == '1) ? hi_r : hi_r + 12'h001);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_idle_after_reset: assert property (disable iff (1'b0) !resetn |=> !dev_sda_oe && !host_sda_oe)
    else $error("line driven right after reset");
  a_dev_hold_high: assert property (scl && dev_sda_oe |=> dev_sda_oe)
    else $error("device released data while clock high");
  a_dev_quiet_high: assert property (scl && !dev_sda_oe |=> !dev_sda_oe)
    else $error("device pulled data while clock high");
  a_drive_after_fall: assert property ($rose(dev_sda_oe) |-> !scl && lo_r >= 12'h002 && lo_r <= 12'h008)
    else $error("device drive not just after clock fall");
  a_release_after_fall: assert property ($fell(dev_sda_oe) |-> !scl && lo_r >= 12'h002 && lo_r <= 12'h008)
    else $error("device release not just after clock fall");
  a_scl_low_len: assert property ($rose(scl) |->
    (lo_r >= LO_MIN && lo_r <= LO_MAX) || (lo_r >= LO2_MIN && lo_r <= LO2_MAX) ||
    (lo_r >= LO3_MIN && lo_r <= LO3_MAX))
    else $error("clock low phase length wrong");
  a_scl_high_len: assert property ($fell(scl) |-> hi_r >= HI_MIN)
    else $error("clock high phase too short");
  a_stop_released: assert property (scl && $fell(host_sda_oe) |-> !dev_sda_oe && sda)
    else $error("stop while device holds data");

  c_dev_drive: cover property ($rose(dev_sda_oe));
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import smbus_cfg_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic power_down_in = 1'b0;
  logic strap = 1'b1;
  logic ref_in = 1'b0;
  logic req_valid = 1'b0;
  op_e req_op = OP_BYTE_WR;
  logic [1:0] req_offset = 2'h0;
  logic [7:0] req_count = 8'h00;
  logic [NUM_BYTES-1:0][7:0] req_wdata = '0;
  logic req_ready, done, nack_err, ref_out_o, ref_out_oe, freq_100_sel, powered_down, freq_b;
  logic [7:0] rd_count;
  logic [NUM_BYTES-1:0][7:0] rd_data, cfg_bytes, cfg_b;
  logic [7:0] exp0, wire_sh, addr_byte;
  logic [3:0] wire_n = 4'h0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  smbus_if bus();
  smbus_if bus2();

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) ref_in <= ~ref_in;

  smbus_config_slave smbus_config_slave_inst (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
    .power_down_in(power_down_in), .ref_out_freq_strap(strap), .reference_clock_in(ref_in),
    .ref_out_o(ref_out_o), .ref_out_oe(ref_out_oe), .freq_100_sel(freq_100_sel),
    .powered_down(powered_down), .cfg_bytes(cfg_bytes));
  // second device only ever sees a foreign address from the bench
  smbus_config_slave smbus_config_slave_inst_2 (.clk_sys(clk_sys), .resetn(resetn), .bus(bus2),
    .power_down_in(power_down_in), .ref_out_freq_strap(~strap), .reference_clock_in(ref_in),
    .ref_out_o(), .ref_out_oe(), .freq_100_sel(freq_b), .powered_down(), .cfg_bytes(cfg_b));
  smbus_config_host smbus_config_host_inst (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_offset(req_offset),
    .req_count(req_count), .req_wdata(req_wdata), .done(done), .nack_err(nack_err),
    .rd_count(rd_count), .rd_data(rd_data));
  smbus_cfg_checker smbus_cfg_checker_inst (.clk_sys(clk_sys), .resetn(resetn),
    .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));

  // first byte after every start or repeated start, as seen on the wire
  always @(negedge bus.sda) if (bus.scl) wire_n = 4'h0;
  always @(posedge bus.scl) begin
    if (wire_n < 4'h8) begin
      wire_sh = {wire_sh[6:0], bus.sda};
      wire_n++;
      if (wire_n == 4'h8) addr_byte = wire_sh;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      $display("Error at %0t: run took too long", $time);
      end_sim();
    end
  end

  task automatic req(input op_e op, input logic [1:0] off, input logic [7:0] cnt,
                     input logic [31:0] wd, input logic [7:0] exp_addr);
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_op <= op;
    req_offset <= off;
    req_count <= cnt;
    req_wdata <= wd;
    @(negedge clk_sys);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 40000);
    chk(done, 1'b1, "transfer done");
    chk(nack_err, 1'b0, "every byte acked");
    chk(addr_byte, exp_addr, "address byte msb first");
  endtask

  task automatic bb(input logic c, input logic d);
    @(posedge clk_sys);
    bus2.host_scl_oe <= c;
    bus2.host_sda_oe <= d;
    repeat (15) @(posedge clk_sys);
  endtask

  task automatic bb_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bb(1'b1, !v[i]);
      bb(1'b0, !v[i]);
      bb(1'b1, !v[i]);
    end
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    @(negedge clk_sys);
    chk(bus2.sda, 1'b1, "no ack to foreign address");
    bb(1'b1, 1'b0);
  endtask

  task automatic t_power_up();
    exp0 = REG0_DEFAULT | (8'h01 << SEL_BIT);
    repeat (8) @(negedge clk_sys);
    chk(cfg_bytes, {REG3_DEFAULT, REG2_DEFAULT, REG1_DEFAULT, exp0}, "defaults, strap high");
    chk(cfg_b, REGS_DEFAULT, "defaults, strap low");
    chk({ref_out_oe, freq_100_sel, freq_b}, 3'h6, "strap pin and frequency");
    // reference toggles every cycle and passes three flops, so the pin shows its inverse
    chk(ref_out_o ^ ref_in, 1'b1, "reference clock on strap pin");
  endtask

  task automatic t_power_down();
    @(posedge clk_sys) power_down_in <= 1'b1;
    repeat (5) @(negedge clk_sys);
    chk(powered_down, 1'b1, "power-down high");
    @(posedge clk_sys) power_down_in <= 1'b0;
    repeat (5) @(negedge clk_sys);
    chk(powered_down, 1'b0, "power-down low");
  endtask

  task automatic t_foreign();
    bb(1'b0, 1'b0);
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    bb_byte(8'hd6);
    bb_byte(8'h80);
    bb_byte(8'h3c);
    bb(1'b1, 1'b1);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    chk(cfg_b, REGS_DEFAULT, "foreign write ignored");
  endtask

  initial begin
    bus2.host_scl_o = 1'b0;
    bus2.host_sda_o = 1'b0;
    bus2.host_scl_oe = 1'b0;
    bus2.host_sda_oe = 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_power_up();
    t_power_down();
    t_foreign();
    // count 2 of 4: stop after the second byte leaves the rest untouched
    // byte 0 = 51 takes software control with the 96 MHz select
    req(OP_BLK_WR, 2'h0, 8'h02, 32'h1122c351, 8'hd4);
    chk(cfg_bytes, {REG3_DEFAULT, REG2_DEFAULT, 8'hc3, 8'h51}, "block write");
    chk(freq_100_sel, 1'b0, "software frequency select");
    req(OP_BYTE_WR, 2'h2, 8'h00, 32'h00000096, 8'hd4);
    chk(cfg_bytes, {REG3_DEFAULT, 8'h96, 8'hc3, 8'h51}, "byte write at offset 2");
    req(OP_BLK_RD, 2'h0, 8'h00, 32'h0, 8'hd5);
    chk(rd_count, NUM_CNT, "block read count");
    chk(rd_data, {REG3_DEFAULT, 8'h96, 8'hc3, 8'h51}, "block read data");
    req(OP_BYTE_RD, 2'h1, 8'h00, 32'h0, 8'hd5);
    chk({rd_count, rd_data[0]}, 16'h01c3, "byte read at offset 1");
    end_sim();
  end
endmodule
